// ---- logic/stf_feed.sv ----
// sensor triggered feed sequencer top
module stf_feed
    import stf_pkg::*;
(
    input wire logic ref_clk, // 50 MHz clock
    input wire logic rst, // async reset, high
    input wire logic cmd_valid, // command strobe
    input wire stf_cmd_t cmd, // command fields
    output logic cmd_reject, // pulse: command refused, bad or while busy
    input wire logic signed [STF_POS_W-1:0] post_trigger_travel, // signed
    input wire logic [STF_POS_W-1:0] safety_travel_limit, // guard steps
    input wire stf_prof_t prof_in, // live speed and ramps
    input wire logic [STF_ANA_W-1:0] analog_threshold, // analog cut
    input wire logic [STF_ANA_W-1:0] analog_sense_pin, // analog sample
    input wire logic pulse_in_terminal, // input 1, high when open
    input wire logic heading_in_terminal, // input 2
    input wire logic gate_input_pin, // input 3
    input wire logic step_done, // pulse: one step issued
    input wire logic [STF_POS_W-1:0] decel_steps, // ramp down length
    output logic run_q, // motor running
    output logic ccw_q, // direction, high for ccw
    output logic decel_q, // ramp down in progress
    output stf_prof_t prof_q, // profile for this move
    output logic [STF_POS_W-1:0] travel_q, // steps so far
    output logic [STF_POS_W-1:0] trig_pos_q, // latched trigger position
    output logic [STF_POS_W-1:0] target_q, // stop target
    output logic busy_q, // feed in progress
    output logic tx_valid_q, // pulse: send byte
    output logic [7:0] tx_byte_q // byte to host
);
    // ****************************************
    // sensor synchronisers
    // ****************************************
    logic [2:0] pin_raw; // raw digital pins
    logic [2:0] lvl_w; // synchronised levels
    logic [2:0] prev_w; // previous levels
    assign pin_raw = {gate_input_pin, heading_in_terminal, pulse_in_terminal};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            stf_sync u_sync (
                .ref_clk(ref_clk),
                .rst(rst),
                .pin_in(pin_raw[gi]),
                .lvl_q(lvl_w[gi]),
                .prev_q(prev_w[gi])
            );
        end
    endgenerate

    // analog level, two register stages as for pins
    logic ana_s1_q; // compare stage one
    logic ana_q; // compare stage two
    logic ana_prev_q; // previous analog level
    logic ana_hi_w; // sample above threshold
    assign ana_hi_w = analog_sense_pin > analog_threshold;

    // hold last level when equal to threshold
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ana_s1_q <= 1'b0;
            ana_q <= 1'b0;
            ana_prev_q <= 1'b0;
        end else begin
            if (analog_sense_pin != analog_threshold) begin
                ana_s1_q <= ana_hi_w;
            end
            ana_q <= ana_s1_q;
            ana_prev_q <= ana_q;
        end
    end

    // ****************************************
    // command decode
    // ****************************************
    function automatic logic cond_ok(input logic [7:0] c);
        cond_ok = (c == STF_COND_L) || (c == STF_COND_H) ||
                  (c == STF_COND_F) || (c == STF_COND_R);
    endfunction : cond_ok

    function automatic stf_cnd_t cond_dec(input logic [7:0] c);
        if (c == STF_COND_L) cond_dec = STF_CND_LOW;
        else if (c == STF_COND_H) cond_dec = STF_CND_HIGH;
        else if (c == STF_COND_F) cond_dec = STF_CND_FALL;
        else cond_dec = STF_CND_RISE;
    endfunction : cond_dec

    logic sel_ok_w; // selector in range
    logic cmd_ok_w; // command accepted
    assign sel_ok_w = (cmd.sel >= STF_SEL_PULSE) &&
        (cmd.guarded ? (cmd.sel <= STF_SEL_GATE)
                     : (cmd.sel <= STF_SEL_ANA));
    assign cmd_ok_w = cmd_valid && !busy_q && sel_ok_w && cond_ok(cmd.cond);
    assign cmd_reject = cmd_valid && !cmd_ok_w;

    // ****************************************
    // trigger evaluation
    // ****************************************
    logic [2:0] sel_q; // held selector
    stf_cnd_t cnd_q; // held condition
    logic guard_q; // guarded move
    logic cur_w; // selected level now
    logic old_w; // selected level before
    logic trig_w; // condition met

    // pins read 0 when current flows, 1 when open
    assign cur_w = (sel_q == STF_SEL_ANA) ? ana_q :
                   (sel_q == STF_SEL_GATE) ? lvl_w[2] :
                   (sel_q == STF_SEL_HEAD) ? lvl_w[1] : lvl_w[0];
    assign old_w = (sel_q == STF_SEL_ANA) ? ana_prev_q :
                   (sel_q == STF_SEL_GATE) ? prev_w[2] :
                   (sel_q == STF_SEL_HEAD) ? prev_w[1] : prev_w[0];

    // edges from previous versus current sample
    assign trig_w = (cnd_q == STF_CND_LOW) ? !cur_w :
                    (cnd_q == STF_CND_HIGH) ? cur_w :
                    (cnd_q == STF_CND_FALL) ? (old_w && !cur_w) :
                    (!old_w && cur_w);

    // ****************************************
    // sequencer
    // ****************************************
    typedef enum logic [1:0] {
        STF_IDLE, STF_SEEK, STF_STOPPING
    } stf_state_t;
    stf_state_t state_q; // sequencer state
    logic [STF_POS_W-1:0] travel_w; // travel after this cycle's step
    logic [STF_POS_W-1:0] dist_w; // magnitude of post_trigger_travel
    logic limit_w; // guard limit reached
    logic stop_w; // decel point reached

    assign travel_w = step_done ? travel_q + 32'h1 : travel_q;
    assign dist_w = post_trigger_travel[STF_POS_W-1] ?
        STF_POS_ZERO - post_trigger_travel : post_trigger_travel;
    assign limit_w = guard_q && (travel_q >= safety_travel_limit);
    assign stop_w = (target_q - travel_q) <= decel_steps;

    // state and move bookkeeping
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= STF_IDLE;
            run_q <= 1'b0;
            ccw_q <= 1'b0;
            decel_q <= 1'b0;
            prof_q <= '0;
            travel_q <= STF_POS_ZERO;
            trig_pos_q <= STF_POS_ZERO;
            target_q <= STF_POS_ZERO;
            busy_q <= 1'b0;
            sel_q <= STF_SEL_PULSE;
            cnd_q <= STF_CND_LOW;
            guard_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_byte_q <= 8'h0;
        end else begin
            tx_valid_q <= 1'b0;
            case (state_q)
                STF_IDLE: begin
                    if (cmd_ok_w) begin
                        state_q <= STF_SEEK;
                        run_q <= 1'b1;
                        busy_q <= 1'b1;
                        ccw_q <= post_trigger_travel[STF_POS_W-1];
                        prof_q <= prof_in;
                        sel_q <= cmd.sel;
                        cnd_q <= cond_dec(cmd.cond);
                        guard_q <= cmd.guarded;
                        travel_q <= STF_POS_ZERO;
                        decel_q <= 1'b0;
                    end
                end
                STF_SEEK: begin
                    travel_q <= travel_w;
                    if (trig_w) begin
                        state_q <= STF_STOPPING;
                        trig_pos_q <= travel_q;
                        target_q <= travel_q + dist_w;
                    end else if (limit_w) begin
                        state_q <= STF_STOPPING;
                        decel_q <= 1'b1;
                        target_q <= travel_q + decel_steps;
                        tx_valid_q <= 1'b1;
                        tx_byte_q <= STF_BANG;
                    end
                end
                STF_STOPPING: begin
                    travel_q <= travel_w;
                    if (stop_w) begin
                        decel_q <= 1'b1;
                    end
                    if (travel_w >= target_q) begin
                        state_q <= STF_IDLE;
                        run_q <= 1'b0;
                        busy_q <= 1'b0;
                        decel_q <= 1'b0;
                    end
                end
                default: state_q <= STF_IDLE;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    guard_bang_a: assert property (
        (state_q == STF_SEEK && !trig_w && limit_w) |=>
            tx_valid_q && tx_byte_q == STF_BANG)
        else $error("missing bang at guard limit");
    trig_latch_a: assert property (
        (state_q == STF_SEEK && trig_w) |=>
            trig_pos_q == $past(travel_q) && state_q == STF_STOPPING)
        else $error("trigger position not latched");
    dir_sign_a: assert property (
        cmd_ok_w |=> ccw_q == $past(post_trigger_travel[STF_POS_W-1]))
        else $error("direction not from sign");
    sel_guard_a: assert property (
        (cmd_valid && cmd.guarded && cmd.sel == STF_SEL_ANA) |-> cmd_reject)
        else $error("analog accepted for guarded feed");
    sel_plain_a: assert property (
        (cmd_valid && !busy_q && !cmd.guarded && cmd.sel == STF_SEL_ANA &&
         cond_ok(cmd.cond)) |=> busy_q)
        else $error("analog refused for plain feed");
    first_end_a: assert property (
        (state_q == STF_SEEK && (trig_w || limit_w)) |=>
            state_q == STF_STOPPING)
        else $error("run did not end on first event");
    prof_take_a: assert property (
        cmd_ok_w |=> prof_q == $past(prof_in))
        else $error("profile not captured");
    run_busy_a: assert property (
        run_q == busy_q ##0 (state_q == STF_IDLE) == !run_q)
        else $error("run and state disagree");

    cov_trig_c: cover property (state_q == STF_SEEK && trig_w);
    cov_limit_c: cover property (tx_valid_q);
    cov_reject_c: cover property (cmd_reject);
    cov_done_c: cover property (busy_q ##1 !busy_q);
endmodule : stf_feed

// ---- logic/stf_pkg.sv ----
// package for the sensor triggered feed sequencer
package stf_pkg;
    // ****************************************
    // widths and encodings
    // ****************************************
    localparam int STF_POS_W = 32; // step position width
    localparam int STF_ANA_W = 12; // analog sample width
    localparam int STF_RATE_W = 16; // speed and ramp field width
    localparam logic [2:0] STF_SEL_PULSE = 3'h1; // pulse_in_terminal
    localparam logic [2:0] STF_SEL_HEAD = 3'h2; // heading_in_terminal
    localparam logic [2:0] STF_SEL_GATE = 3'h3; // gate_input_pin
    localparam logic [2:0] STF_SEL_ANA = 3'h4; // analog_sense_pin
    localparam logic [7:0] STF_COND_L = 8'h4c; // letter L
    localparam logic [7:0] STF_COND_H = 8'h48; // letter H
    localparam logic [7:0] STF_COND_F = 8'h46; // letter F
    localparam logic [7:0] STF_COND_R = 8'h52; // letter R
    localparam logic [7:0] STF_BANG = 8'h21; // exclamation character
    localparam logic [1:0] STF_SYNC_RST = 2'h3; // idle pins read open
    localparam logic [STF_POS_W-1:0] STF_POS_ZERO = 32'h0; // zero distance

    // ****************************************
    // carried groups
    // ****************************************
    typedef struct packed {
        logic [STF_RATE_W-1:0] speed; // cruise_speed
        logic [STF_RATE_W-1:0] accel; // speedup_rate
        logic [STF_RATE_W-1:0] decel; // slowdown_rate
    } stf_prof_t;

    typedef struct packed {
        logic guarded; // guarded_sensor_feed_cmd
        logic [2:0] sel; // input selector
        logic [7:0] cond; // condition letter
    } stf_cmd_t;

    typedef enum logic [1:0] {
        STF_CND_LOW, STF_CND_HIGH, STF_CND_FALL, STF_CND_RISE
    } stf_cnd_t;
endpackage : stf_pkg

// ---- logic/stf_sync.sv ----
// two flop synchroniser with edge history for the sensor pins
module stf_sync
    import stf_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic pin_in, // raw pin level
    output logic lvl_q, // synchronised level
    output logic prev_q // previous synchronised level
);
    // ****************************************
    // sync chain
    // ****************************************
    logic [1:0] sync_q; // first flop feeds only the second

    // two flops then history
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_q <= STF_SYNC_RST;
            prev_q <= 1'b1;
        end else begin
            sync_q <= {sync_q[0], pin_in};
            prev_q <= sync_q[1];
        end
    end
    assign lvl_q = sync_q[1];
endmodule : stf_sync

// ---- test/stf_host_model.sv ----
// far side model: step pulse source and host byte sink
module stf_host_model
    import stf_pkg::*;
#(
    parameter int GAP = 1 // idle cycles between steps
)
(
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic run_q, // motor running
    input wire logic tx_valid_q, // pulse: byte to host
    input wire logic [7:0] tx_byte_q, // byte to host
    output logic step_done, // pulse: one step issued
    output int bang_cnt // bang bytes seen by the host
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap_q; // spacing counter
    // ****************************************
    // steps only while the drive runs
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gap_q <= 0;
            step_done <= 1'b0;
        end else if (run_q && gap_q >= GAP) begin
            gap_q <= 0;
            step_done <= 1'b1;
        end else begin
            gap_q <= gap_q + 1;
            step_done <= 1'b0;
        end
    end
    // host counts each bang byte it takes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bang_cnt <= 0;
        end else if (tx_valid_q && tx_byte_q == STF_BANG) begin
            bang_cnt <= bang_cnt + 1;
        end
    end
endmodule : stf_host_model

// ---- test/tb.sv ----
// self-checking bench for the sensor feed sequencer
module tb;
    import stf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, cmd_valid, cmd_reject, step_done;
    stf_cmd_t cmd; // command fields
    logic signed [31:0] ptt; // post_trigger_travel
    logic [31:0] lim, dsteps, travel_q, trig_pos_q, target_q;
    stf_prof_t prof_in, prof_q; // profile in and out
    logic [11:0] ath, ana; // analog cut and sample
    logic p1, p2, p3, run_q, ccw_q, decel_q, busy_q, tx_valid_q;
    logic [7:0] tx_byte_q; // byte to host
    int bang_cnt, n_errors, num_checks, cyc;
    stf_feed u_stf_feed (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_reject(cmd_reject), .post_trigger_travel(ptt),
        .safety_travel_limit(lim), .prof_in(prof_in), .analog_threshold(ath),
        .analog_sense_pin(ana), .pulse_in_terminal(p1),
        .heading_in_terminal(p2), .gate_input_pin(p3), .step_done(step_done),
        .decel_steps(dsteps), .run_q(run_q), .ccw_q(ccw_q), .decel_q(decel_q),
        .prof_q(prof_q), .travel_q(travel_q), .trig_pos_q(trig_pos_q),
        .target_q(target_q), .busy_q(busy_q), .tx_valid_q(tx_valid_q),
        .tx_byte_q(tx_byte_q));
    stf_host_model u_stf_host_model (.ref_clk(ref_clk), .rst(rst),
        .run_q(run_q), .tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q),
        .step_done(step_done), .bang_cnt(bang_cnt));
    // ****************************************
    // clock, timeout, verdict
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // cut a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            complete_run();
        end
    end
    task complete_run;
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    // single comparison point
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // ****************************************
    // shared drivers
    // ****************************************
    task send(input logic g, input logic [2:0] s, input logic [7:0] c,
              input logic rej);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd = '{guarded: g, sel: s, cond: c};
        #1 check(cmd_reject, rej);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask : send
    // bounded wait for the feed to end
    task wait_idle;
        int k;
        k = 0;
        while (busy_q !== 1'b0 && k < 3000) begin
            @(negedge ref_clk);
            k++;
        end
        check(busy_q, 1'b0);
    endtask : wait_idle
    // ****************************************
    // scenarios
    // ****************************************
    // plain ccw feed, energized pin ends it, profile latched
    task t_plain_low;
        int k;
        logic [31:0] t0;
        ptt = -32'sd40;
        prof_in = {16'h0010, 16'h0020, 16'h0030};
        send(1'b0, STF_SEL_PULSE, STF_COND_L, 1'b0);
        check(run_q, 1'b1);
        check(ccw_q, 1'b1);
        check(prof_q.speed, 16'h0010);
        check(prof_q.accel, 16'h0020);
        check(prof_q.decel, 16'h0030);
        repeat (8) @(negedge ref_clk);
        check(busy_q, 1'b1);
        t0 = travel_q;
        p1 = 1'b0;
        // ramp down must start within decel_steps of the target
        k = 0;
        while (decel_q !== 1'b1 && k < 300) begin
            @(negedge ref_clk);
            k++;
        end
        check(decel_q, 1'b1);
        check(target_q - travel_q <= dsteps, 1'b1);
        wait_idle();
        check(target_q, trig_pos_q + 32'h28);
        check(travel_q, target_q);
        check(trig_pos_q - t0 <= 32'h2, 1'b1);
        p1 = 1'b1;
    endtask : t_plain_low
    // guarded cw feed, rising edge wins before the limit
    task t_guard_rise;
        ptt = 32'sd25;
        lim = 32'h3e8;
        p2 = 1'b0;
        send(1'b1, STF_SEL_HEAD, STF_COND_R, 1'b0);
        check(ccw_q, 1'b0);
        repeat (10) @(negedge ref_clk);
        p2 = 1'b1;
        wait_idle();
        check(target_q, trig_pos_q + 32'h19);
        check(bang_cnt, 0);
    endtask : t_guard_rise
    // guarded feed never triggers: bang and decel from limit
    task t_guard_limit;
        int k, b0;
        b0 = bang_cnt;
        lim = 32'h1e;
        send(1'b1, STF_SEL_GATE, STF_COND_L, 1'b0);
        k = 0;
        while (tx_valid_q !== 1'b1 && k < 500) begin
            @(posedge ref_clk);
            #1 k++;
        end
        check(tx_byte_q, STF_BANG);
        check(decel_q, 1'b1);
        wait_idle();
        check(bang_cnt, b0 + 1);
        check(travel_q, lim + dsteps);
        check(run_q, 1'b0);
    endtask : t_guard_limit
    // refused commands and a command while busy
    task t_reject;
        send(1'b1, STF_SEL_ANA, STF_COND_L, 1'b1);
        send(1'b0, 3'h0, STF_COND_H, 1'b1);
        send(1'b0, STF_SEL_PULSE, 8'h58, 1'b1);
        check(busy_q, 1'b0);
        send(1'b0, STF_SEL_PULSE, STF_COND_L, 1'b0);
        send(1'b0, STF_SEL_HEAD, STF_COND_H, 1'b1);
        p1 = 1'b0;
        wait_idle();
        p1 = 1'b1;
    endtask : t_reject
    // analog input with every condition letter
    task t_analog;
        logic [7:0] lt [4];
        logic [11:0] st [4];
        logic [11:0] en [4];
        lt = '{STF_COND_L, STF_COND_H, STF_COND_F, STF_COND_R};
        st = '{12'h900, 12'h100, 12'h900, 12'h100};
        en = '{12'h100, 12'h900, 12'h100, 12'h900};
        ptt = 32'sd12;
        for (int i = 0; i < 4; i++) begin
            ana = st[i];
            repeat (4) @(negedge ref_clk);
            send(1'b0, STF_SEL_ANA, lt[i], 1'b0);
            repeat (6) @(negedge ref_clk);
            check(busy_q, 1'b1);
            ana = en[i];
            wait_idle();
            check(target_q, trig_pos_q + 32'hc);
        end
    endtask : t_analog
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        ptt = '0;
        lim = 32'h3e8;
        dsteps = 32'h5;
        prof_in = '0;
        ath = 12'h800;
        ana = 12'h100;
        p1 = 1'b1;
        p2 = 1'b1;
        p3 = 1'b1;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        t_plain_low();
        t_guard_rise();
        t_guard_limit();
        t_reject();
        t_analog();
        complete_run();
    end
endmodule : tb
